/* File: hbt_pkg.sv */
package hbt_pkg;
  // APB byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  // Host port register select
  localparam logic HADDR_CTRL = 1'b0;
  localparam logic HADDR_MASK = 1'b1;
  // Control register bit positions, and the host mask register enable bit
  localparam int B_WBUSY = 7;
  localparam int B_RBUSY = 6;
  localparam int B_USER  = 5;
  localparam int B_EVT   = 4;
  localparam int B_S2H   = 3;
  localparam int B_H2B   = 2;
  localparam int B_HIEN  = 0;
  // Reset values
  localparam logic RST_WBUSY = 1'b1;
  localparam logic RST_FLAG  = 1'b0;
  // Slave interrupt status bits
  localparam int NEV       = 5;
  localparam int EV_H2B    = 0;
  localparam int EV_S2HCLR = 1;
  localparam int EV_EVTCLR = 2;
  localparam int EV_RBUSY  = 3;
  localparam int EV_USER   = 4;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       addr;
    logic [7:0] wdata;
  } hbt_host_req_t;

  typedef struct packed {
    logic           wbusy;
    logic           rbusy;
    logic           user;
    logic           evt;
    logic           s2h;
    logic           h2b;
    logic           recValid;
    logic [7:0]     recVal;
    logic           hostIrqEn;
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic [7:0]     hostRdData;
    logic           hostIrq;
    logic           slaveIrq;
  } hbt_state_t;
endpackage

/* File: hbt_flags.sv */
// Notes on behaviour
// RULE1 - Write busy bit 7 resets to 1, the slave reads and writes it, the host only reads it.
// RULE2 - Write busy reading 0 shows the host that no write transfer holds the buffer.
// RULE3 - Read busy bit 6 resets to 0 and is read-only to the slave.
// RULE4 - Every host write of 1 to read busy inverts it.
// RULE5 - User flag bit 5 resets to 0, a host write of 0 sets it, a host 1 leaves it.
// RULE6 - A slave write of 0 clears the user flag only after the slave read it as 1.
// RULE7 - A slave write of 1 sets the user flag only after the slave read it as 0.
// RULE8 - Event flag bit 4 resets to 0 and a slave 1 sets it only after a read of 0.
// RULE9 - A host write of 1 clears the event flag.
// RULE10 - The event flag drives the host interrupt only while the host enable is set.
// RULE11 - Slave-write-complete bit 3 resets to 0 and a slave 1 sets it after a read of 0.
// RULE12 - A host write of 1 clears slave-write-complete once the host has read the buffer; the code clears it on any host write of 1.
// RULE13 - Slave-write-complete drives the host interrupt only while the host enable is set.
// RULE14 - Host-write-complete bit 2 resets to 0 and a host write of 1 sets it.
// RULE15 - A slave write of 0 clears host-write-complete only after a read of 1.
// RULE16 - The write value with no effect for a flag is ignored on either side.
// RULE17 - The last slave read value is recorded and gates each qualifying slave write.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module hbt_flags
  import hbt_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire hbt_host_req_t hostReq,
  output logic [7:0]         hostRdData,
  output logic               hostIrq,
  output logic               slaveIrq
);
  logic       rstMeta;
  logic       rstSync;
  hbt_state_t r;
  hbt_state_t next_r;
  logic       acc;
  logic       done;
  logic       sw;
  logic       hw;
  logic       rdCtrl;
  logic       rdStat;
  logic [7:0] w;
  logic [7:0] hd;
  logic       userSet;
  logic       userClr;
  logic       evtSet;
  logic       s2hSet;
  logic       h2bClr;
  logic [NEV-1:0] ev;

  function automatic logic [7:0] ctrlByte(input hbt_state_t s);
    ctrlByte = {s.wbusy, s.rbusy, s.user, s.evt, s.s2h, s.h2b, 2'b00};
  endfunction

  // Release reset through two flops so no flag leaves reset on a ragged edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  always_comb begin
    next_r = r;
    acc    = psel & penable;
    done   = acc & r.pready;
    sw     = done & pwrite & (paddr == OFF_CTRL);
    rdCtrl = done & ~pwrite & (paddr == OFF_CTRL);
    rdStat = done & ~pwrite & (paddr == OFF_STAT);
    w      = pwdata[7:0];
    hw     = hostReq.wr & (hostReq.addr == HADDR_CTRL);
    hd     = hostReq.wdata;

    // One wait state so read data can leave a flop
    next_r.pready  = acc & ~r.pready;
    // Error flag stands only beside its ready pulse
    next_r.pslverr = 1'b0;
    if (acc & ~r.pready) begin
      unique case (paddr)
        OFF_CTRL: next_r.prdata = {24'h000000, ctrlByte(r)};
        OFF_STAT: next_r.prdata = {{(32-NEV){1'b0}}, r.status};
        OFF_MASK: next_r.prdata = {{(32-NEV){1'b0}}, r.mask};
        default: begin
          next_r.prdata  = 32'h00000000;
          next_r.pslverr = 1'b1;
        end
      endcase
    end

    if (sw) begin
      next_r.wbusy = w[B_WBUSY]; // RULE1 RULE2
    end
    if (hw & hd[B_RBUSY]) begin
      next_r.rbusy = ~r.rbusy; // RULE3 RULE4
    end

    userSet = (hw & ~hd[B_USER]) // RULE5
            | (sw & w[B_USER] & r.recValid & ~r.recVal[B_USER]); // RULE7 RULE17
    userClr = sw & ~w[B_USER] & r.recValid & r.recVal[B_USER]; // RULE6 RULE17
    // Set wins over a clear in the same cycle
    next_r.user = userSet | (r.user & ~userClr); // RULE16

    evtSet = sw & w[B_EVT] & r.recValid & ~r.recVal[B_EVT]; // RULE8 RULE17
    next_r.evt = evtSet | (r.evt & ~(hw & hd[B_EVT])); // RULE9 RULE16

    s2hSet = sw & w[B_S2H] & r.recValid & ~r.recVal[B_S2H]; // RULE11 RULE17
    next_r.s2h = s2hSet | (r.s2h & ~(hw & hd[B_S2H])); // RULE12 RULE16

    h2bClr = sw & ~w[B_H2B] & r.recValid & r.recVal[B_H2B]; // RULE15 RULE17
    next_r.h2b = (hw & hd[B_H2B]) | (r.h2b & ~h2bClr); // RULE14 RULE16

    // The record is the value actually returned; any slave control write consumes it, host writes leave it
    if (rdCtrl) begin
      next_r.recValid = 1'b1; // RULE17
      next_r.recVal   = r.prdata[7:0];
    end else if (sw) begin
      next_r.recValid = 1'b0;
    end

    if (hostReq.wr & (hostReq.addr == HADDR_MASK)) begin
      next_r.hostIrqEn = hd[B_HIEN];
    end
    if (done & pwrite & (paddr == OFF_MASK)) begin
      next_r.mask = pwdata[NEV-1:0];
    end

    ev            = '0;
    ev[EV_H2B]    = hw & hd[B_H2B];
    ev[EV_S2HCLR] = hw & hd[B_S2H] & r.s2h;
    ev[EV_EVTCLR] = hw & hd[B_EVT] & r.evt;
    ev[EV_RBUSY]  = hw & hd[B_RBUSY];
    ev[EV_USER]   = hw & ~hd[B_USER];
    // Only bits that were returned are cleared, so a late event survives
    next_r.status = (r.status & ~(rdStat ? r.prdata[NEV-1:0] : '0)) | ev;

    if (hostReq.rd) begin
      next_r.hostRdData = (hostReq.addr == HADDR_CTRL) ? ctrlByte(r)
                        : {7'h00, r.hostIrqEn};
    end

    next_r.hostIrq  = next_r.hostIrqEn & (next_r.evt | next_r.s2h); // RULE10 RULE13
    next_r.slaveIrq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      r       <= '0;
      r.wbusy <= RST_WBUSY;
      r.rbusy <= RST_FLAG;
      r.user  <= RST_FLAG;
      r.evt   <= RST_FLAG;
      r.s2h   <= RST_FLAG;
      r.h2b   <= RST_FLAG;
    end else begin
      r <= next_r;
    end
  end

  assign pready     = r.pready;
  assign prdata     = r.prdata;
  assign pslverr    = r.pslverr;
  assign hostRdData = r.hostRdData;
  assign hostIrq    = r.hostIrq;
  assign slaveIrq   = r.slaveIrq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSync);

  AST_WBUSY_SW: assert property (sw |=> r.wbusy == $past(pwdata[B_WBUSY])) // RULE1
    else $error("write busy did not follow slave write");
  AST_WBUSY_HOLD: assert property (!sw |=> $stable(r.wbusy)) // RULE1
    else $error("write busy changed without slave write");
  AST_RBUSY_TGL: assert property (hw && hd[B_RBUSY] |=> r.rbusy != $past(r.rbusy)) // RULE4
    else $error("read busy did not toggle");
  AST_RBUSY_HOLD: assert property (!(hw && hd[B_RBUSY]) |=> $stable(r.rbusy)) // RULE3
    else $error("read busy changed without host toggle");
  AST_USER_HOST: assert property (hw && !hd[B_USER] |=> r.user) // RULE5
    else $error("host write of 0 did not set user flag");
  AST_USER_RISE: assert property ($rose(r.user) |-> $past(userSet)) // RULE7
    else $error("user flag set without a qualifying write");
  AST_USER_FALL: assert property ($fell(r.user) |->
      $past(sw && !pwdata[B_USER] && r.recValid && r.recVal[B_USER])) // RULE6
    else $error("user flag cleared without read of 1");
  AST_EVT_RISE: assert property ($rose(r.evt) |->
      $past(sw && pwdata[B_EVT] && r.recValid && !r.recVal[B_EVT])) // RULE8
    else $error("event flag set without read of 0");
  AST_EVT_CLR: assert property (hw && hd[B_EVT] && !evtSet |=> !r.evt) // RULE9
    else $error("host write of 1 did not clear event flag");
  AST_S2H_CLR: assert property (hw && hd[B_S2H] && !s2hSet |=> !r.s2h) // RULE12
    else $error("host write of 1 did not clear write complete");
  AST_H2B_SET: assert property (hw && hd[B_H2B] |=> r.h2b) // RULE14
    else $error("host write of 1 did not set host complete");
  AST_H2B_FALL: assert property ($fell(r.h2b) |->
      $past(sw && !pwdata[B_H2B] && r.recValid && r.recVal[B_H2B])) // RULE15
    else $error("host complete cleared without read of 1");
  AST_HIRQ: assert property (r.hostIrq |-> r.hostIrqEn && (r.evt || r.s2h)) // RULE10
    else $error("host interrupt without enabled source");
  AST_PREADY: assert property (acc && !r.pready |=> r.pready ##1 !r.pready)
    else $error("apb answer not one wait state");

  // Slave bus answer
  AST_PSLVERR: assert property (
      r.pslverr |-> r.pready
    )
    else $error("error flag outside its ready pulse");

  AST_RD_CTRL: assert property (
      acc && !r.pready && paddr == OFF_CTRL |=> r.prdata == {24'h000000, $past(ctrlByte(r))}
    ) // RULE2
    else $error("control read data wrong");

  AST_MASK_WR: assert property (
      done && pwrite && paddr == OFF_MASK |=> r.mask == $past(pwdata[NEV-1:0])
    )
    else $error("slave mask write lost");

  // Read record
  AST_REC_TAKE: assert property (
      rdCtrl |=> r.recValid && r.recVal == $past(r.prdata[7:0])
    ) // RULE17
    else $error("read record not taken");

  AST_REC_DROP: assert property (
      sw |=> !r.recValid
    ) // RULE17
    else $error("read record survived a write");

  AST_NOREC_HOLD: assert property (
      sw && !r.recValid && !hw |=> $stable(r.user) && $stable(r.evt) && $stable(r.s2h)
        && $stable(r.h2b)
    ) // RULE17
    else $error("slave write acted without a read");

  // Read busy
  AST_RBUSY_SLAVE_RO: assert property (
      sw && !(hw && hd[B_RBUSY]) |=> $stable(r.rbusy)
    ) // RULE3
    else $error("slave write moved read busy");

  // User flag
  AST_USER_HOST_ONE: assert property (
      hw && hd[B_USER] && !sw |=> $stable(r.user)
    ) // RULE16
    else $error("host write of 1 moved user flag");

  AST_USER_SLV_SET: assert property (
      sw && w[B_USER] && r.recValid && !r.recVal[B_USER] |=> r.user
    ) // RULE7
    else $error("qualified slave set of user flag lost");

  AST_USER_SLV_CLR: assert property (
      sw && !w[B_USER] && r.recValid && r.recVal[B_USER] && !(hw && !hd[B_USER]) |=> !r.user
    ) // RULE6
    else $error("qualified slave clear of user flag lost");

  AST_USER_BAD_SET: assert property (
      sw && w[B_USER] && r.recValid && r.recVal[B_USER] && !hw |=> $stable(r.user)
    ) // RULE7
    else $error("user flag set after a read of 1");

  AST_USER_BAD_CLR: assert property (
      sw && !w[B_USER] && r.recValid && !r.recVal[B_USER] && !hw |=> $stable(r.user)
    ) // RULE6
    else $error("user flag cleared after a read of 0");

  // Event flag
  AST_EVT_SET: assert property (
      sw && w[B_EVT] && r.recValid && !r.recVal[B_EVT] |=> r.evt
    ) // RULE8
    else $error("qualified event set lost");

  AST_EVT_HOST_ZERO: assert property (
      hw && !hd[B_EVT] && !evtSet |=> $stable(r.evt)
    ) // RULE16
    else $error("host write of 0 moved event flag");

  AST_EVT_SLV_ZERO: assert property (
      sw && !w[B_EVT] && !(hw && hd[B_EVT]) |=> $stable(r.evt)
    ) // RULE16
    else $error("slave write of 0 moved event flag");

  // Slave write complete
  AST_S2H_SET: assert property (
      sw && w[B_S2H] && r.recValid && !r.recVal[B_S2H] |=> r.s2h
    ) // RULE11
    else $error("qualified write complete set lost");

  AST_S2H_RISE: assert property (
      $rose(r.s2h) |-> $past(s2hSet)
    ) // RULE11
    else $error("write complete set without a read of 0");

  AST_S2H_HOST_ZERO: assert property (
      hw && !hd[B_S2H] && !s2hSet |=> $stable(r.s2h)
    ) // RULE16
    else $error("host write of 0 moved write complete");

  AST_S2H_SLV_ZERO: assert property (
      sw && !w[B_S2H] && !(hw && hd[B_S2H]) |=> $stable(r.s2h)
    ) // RULE16
    else $error("slave write of 0 moved write complete");

  // Host write complete
  AST_H2B_RISE: assert property (
      $rose(r.h2b) |-> $past(hw && hd[B_H2B])
    ) // RULE14
    else $error("host complete set without host write");

  AST_H2B_SLV_CLR: assert property (
      sw && !w[B_H2B] && r.recValid && r.recVal[B_H2B] && !(hw && hd[B_H2B]) |=> !r.h2b
    ) // RULE15
    else $error("qualified host complete clear lost");

  AST_H2B_SLV_ONE: assert property (
      sw && w[B_H2B] && !(hw && hd[B_H2B]) |=> $stable(r.h2b)
    ) // RULE16
    else $error("slave write of 1 moved host complete");

  // Host port
  AST_HIEN_WR: assert property (
      hostReq.wr && hostReq.addr == HADDR_MASK |=> r.hostIrqEn == $past(hd[B_HIEN])
    ) // RULE10
    else $error("host interrupt enable write lost");

  AST_HRD_CTRL: assert property (
      hostReq.rd && hostReq.addr == HADDR_CTRL |=> r.hostRdData == $past(ctrlByte(r))
    ) // RULE2
    else $error("host control read data wrong");

  AST_HRD_MASK: assert property (
      hostReq.rd && hostReq.addr == HADDR_MASK |=> r.hostRdData == {7'h00, $past(r.hostIrqEn)}
    )
    else $error("host mask read data wrong");

  AST_HRD_HOLD: assert property (
      !hostReq.rd |=> $stable(r.hostRdData)
    )
    else $error("host read data moved without a read");

  // Interrupts
  AST_HIRQ_ON: assert property (
      r.hostIrqEn && (r.evt || r.s2h) |-> r.hostIrq
    ) // RULE10 RULE13
    else $error("enabled host interrupt source not raised");

  AST_SIRQ: assert property (
      r.slaveIrq == (|(r.status & r.mask))
    )
    else $error("slave interrupt does not follow status and mask");

  AST_STAT_H2B: assert property (
      hw && hd[B_H2B] |=> r.status[EV_H2B]
    )
    else $error("host complete event not recorded");

  AST_STAT_RBUSY: assert property (
      hw && hd[B_RBUSY] |=> r.status[EV_RBUSY]
    )
    else $error("read busy event not recorded");

  // Returned bits must clear when no host write lands in the read cycle
  AST_STAT_CLR: assert property (
      rdStat && !hw |=> (r.status & $past(r.prdata[NEV-1:0])) == {NEV{1'b0}}
    )
    else $error("status bits returned were not cleared");

  COV_TOGGLE: cover property (hw && hd[B_RBUSY] ##1 hw && hd[B_RBUSY]);
  COV_EVT: cover property (rdCtrl ##[1:4] $rose(r.evt) ##[1:8] r.hostIrq);
  COV_H2B: cover property ($rose(r.h2b) ##[1:20] $fell(r.h2b));
  COV_SIRQ: cover property ($rose(r.slaveIrq));
  COV_S2H: cover property ($rose(r.s2h) ##[1:20] $fell(r.s2h));
endmodule

/* File: hbt_host_model.sv */
`timescale 1ns/1ps
module hbt_host_model
  import hbt_pkg::*;
(
  input  wire logic       mclk,
  output hbt_host_req_t   req,
  input  wire logic [7:0] rdData
);
  initial req = '0;
  // One strobe cycle per access; data flipped after so stale bytes never look valid
  task automatic hwr(input logic a, input logic [7:0] v);
    @(posedge mclk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= v;
    @(posedge mclk);
    req.wr    <= 1'b0;
    req.wdata <= ~v;
  endtask
  task automatic hrd(input logic a, output logic [7:0] v);
    @(posedge mclk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge mclk);
    req.rd <= 1'b0;
    @(posedge mclk);
    v = rdData;
  endtask
endmodule

/* File: test_block_transfer_handshake_flags.sv */
`timescale 1ns/1ps
module test_block_transfer_handshake_flags
  import hbt_pkg::*;
;
  logic          mclk, arst_n, psel, penable, pwrite, pready, pslverr, hostIrq, slaveIrq;
  logic [7:0]    paddr, hostRdData, v;
  logic [31:0]   pwdata, prdata, r;
  hbt_host_req_t hostReq;
  logic [32:0]   expQ[$];
  int            errors, compares, cyc;

  hbt_flags DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .hostReq(hostReq), .hostRdData(hostRdData), .hostIrq(hostIrq),
    .slaveIrq(slaveIrq));
  hbt_host_model host (.mclk(mclk), .req(hostReq), .rdData(hostRdData));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apbRd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic hchk(input logic a, input logic [7:0] e);
    host.hrd(a, v);
    check({25'h0, v}, {25'h0, e});
  endtask

  // Levels are given one spare edge since both interrupt lines are registered with the flags
  task automatic irq(input logic h, input logic s);
    @(posedge mclk);
    check({32'h0, hostIrq}, {32'h0, h});
    check({32'h0, slaveIrq}, {32'h0, s});
  endtask

  // Read data is compared where the master takes it
  always @(posedge mclk)
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, expQ.pop_front());

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    r = $urandom(32'h89e4);
    apbRd(OFF_CTRL, 33'h80);
    hchk(HADDR_CTRL, 8'h80);
    host.hwr(HADDR_CTRL, 8'ha0);
    hchk(HADDR_CTRL, 8'h80);
    host.hwr(HADDR_CTRL, 8'h40);
    host.hwr(HADDR_CTRL, 8'h00);
    hchk(HADDR_CTRL, 8'he0);
    host.hwr(HADDR_CTRL, 8'h40);
    apbRd(OFF_CTRL, 33'ha0);
    apb(1'b1, OFF_CTRL, 32'h18);
    apbRd(OFF_CTRL, 33'h18);
    irq(1'b0, 1'b0);
    host.hwr(HADDR_MASK, 8'h01);
    irq(1'b1, 1'b0);
    host.hwr(HADDR_CTRL, 8'h10);
    irq(1'b1, 1'b0);
    host.hwr(HADDR_CTRL, 8'h08);
    irq(1'b0, 1'b0);
    host.hwr(HADDR_CTRL, 8'h04);
    apbRd(OFF_CTRL, 33'h24);
    apb(1'b1, OFF_CTRL, 32'h00);
    host.hwr(HADDR_CTRL, 8'h04);
    apb(1'b1, OFF_CTRL, 32'h10);
    apbRd(OFF_CTRL, 33'h24);
    apb(1'b1, OFF_MASK, 32'h1f);
    irq(1'b0, 1'b1);
    apbRd(OFF_STAT, 33'h1f);
    irq(1'b0, 1'b0);
    apbRd(OFF_STAT, 33'h0);
    apbRd(8'h0c, {1'b1, 32'h0});
    repeat (4) begin
      r = $urandom;
      host.hwr(HADDR_MASK, r[7:0]);
      hchk(HADDR_MASK, {7'h0, r[0]});
    end
    apbRd(OFF_MASK, 33'h1f);
    repeat (2) @(posedge mclk);
    complete_run();
  end
endmodule
